// ==== inc/ici_pkg.sv ====
`default_nettype none
package ici_pkg;

   // ****
   // Command codes
   // ****
   localparam logic [7:0] CMD_INIT         = 8'h40;
   localparam logic [7:0] CMD_STANDBY      = 8'h53;
   localparam logic [7:0] CMD_SCREEN_OFF   = 8'h58;
   localparam logic [7:0] CMD_SCREEN_ON    = 8'h59;
   localparam logic [7:0] CMD_BLOCKS       = 8'h44;
   localparam logic [7:0] CMD_POINTER_FORM = 8'h5d;
   localparam logic [7:0] CMD_DIR_BASE     = 8'h4c;
   localparam logic [7:0] CMD_DIR_MASK     = 8'hfc;
   localparam logic [7:0] CMD_DIR_BITS     = 8'h03;
   localparam logic [7:0] CMD_LAYER_MIX    = 8'h5b;
   localparam logic [7:0] CMD_GLYPH_BASE   = 8'h5c;
   localparam logic [7:0] CMD_FINE_SHIFT   = 8'h5a;
   localparam logic [7:0] CMD_PTR_SET      = 8'h46;
   localparam logic [7:0] CMD_PTR_GET      = 8'h47;
   localparam logic [7:0] CMD_DEPTH        = 8'h60;
   localparam logic [7:0] CMD_STORE        = 8'h42;
   localparam logic [7:0] CMD_FETCH        = 8'h43;

   // ****
   // Configuration register indexes and lengths
   // ****
   localparam int         RF_AW      = 6;
   localparam int         RF_DEPTH   = 64;
   localparam logic [5:0] IDX_INIT   = 6'h00;
   localparam logic [5:0] IDX_ATTR   = 6'h0a;
   localparam logic [5:0] IDX_BLOCKS = 6'h0b;
   localparam logic [5:0] IDX_FORM   = 6'h15;
   localparam logic [5:0] IDX_DIR    = 6'h17;
   localparam logic [5:0] IDX_MIX    = 6'h18;
   localparam logic [5:0] IDX_GLYPH  = 6'h19;
   localparam logic [5:0] IDX_SHIFT  = 6'h1b;
   localparam logic [5:0] IDX_PTR    = 6'h1c;
   localparam logic [5:0] IDX_DEPTH  = 6'h20;
   localparam logic [5:0] IDX_LAST   = 6'h20;
   localparam logic [7:0] RF_RESET   = 8'h00;

   localparam logic [4:0] LEN_NONE   = 5'h00;
   localparam logic [4:0] LEN_ONE    = 5'h01;
   localparam logic [4:0] LEN_TWO    = 5'h02;
   localparam logic [4:0] LEN_INIT   = 5'h08;
   localparam logic [4:0] LEN_BLOCKS = 5'h0a;

   // ****
   // Initialization parameter fields
   // ****
   localparam logic [7:0] P1_KEEP     = 8'h2d;
   localparam logic [7:0] P1_ONE      = 8'h10;
   localparam logic [7:0] P2_KEEP     = 8'h8f;
   localparam logic [3:0] OFS_P1      = 4'h0;
   localparam logic [3:0] OFS_P2      = 4'h1;
   localparam int         BIT_ORIGIN  = 5;
   localparam int         BIT_PANEL   = 3;
   localparam int         BIT_GHEIGHT = 2;
   localparam int         BIT_GSRC    = 0;
   localparam int         BIT_ACFRAME = 7;

   // ****
   // Host bus modes and Wishbone map
   // ****
   localparam logic [1:0]  MODE_GENERIC = 2'h0;
   localparam logic [1:0]  MODE_ENABLE  = 2'h1;
   localparam logic [1:0]  MODE_DSTROBE = 2'h2;
   localparam logic [9:0]  WB_CFG_PAGE  = 10'h200;
   localparam logic [15:0] WB_CTRL_IDX  = 16'h8030;
   localparam logic [15:0] WB_STAT_IDX  = 16'h8031;

   typedef enum logic [2:0] {
      ICI_K_IDLE   = 3'b000,
      ICI_K_PARAM  = 3'b001,
      ICI_K_STORE  = 3'b010,
      ICI_K_FETCH  = 3'b011,
      ICI_K_PTRGET = 3'b100
   } ici_kind_t;

   typedef enum logic [1:0] {
      ICI_A_NONE = 2'b00,
      ICI_A_CMD  = 2'b01,
      ICI_A_PWR  = 2'b10,
      ICI_A_PRD  = 2'b11
   } ici_acc_t;

endpackage
`default_nettype wire

// ==== hw/ici_regfile.sv ====
`timescale 1ns/100ps
`default_nettype none
module ici_regfile (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      we_i,
   input  wire logic [ici_pkg::RF_AW-1:0] waddr_i,
   input  wire logic [7:0]                wdata_i,
   input  wire logic [ici_pkg::RF_AW-1:0] raddr_i,
   output logic      [7:0]                rdata_o
);
   import ici_pkg::*;

   logic [RF_DEPTH-1:0][7:0] mem_q;

   // Every entry clears so defaults read back as zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < RF_DEPTH; i++) begin
            mem_q[i] <= RF_RESET;
         end
         rdata_o <= RF_RESET;
      end else begin
         if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
         end
         rdata_o <= mem_q[raddr_i];
      end
   end

endmodule
`default_nettype wire

// ==== hw/ici_core.sv ====
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Code 40h takes eight bytes into configuration slots 00h to 07h.
// - Standby after reset and after code 53h; code 40h leaves standby.
// - Normal state is reported only after the eighth init byte lands.
// - Codes 59h on and 58h off each store one attribute byte at 0Ah.
// - Code 44h stores ten block bytes into slots 0Bh to 14h.
// - Codes 4Ch to 4Fh store their two low bits at slot 17h.
// - Code 5Bh stores one layer mixing byte at slot 18h.
// - Code 5Ch stores glyph RAM base, low byte first, at 19h and 1Ah.
// - Code 5Ah stores one fine shift byte at slot 1Bh.
// - Code 60h stores one depth byte at slot 20h.
// - Generic bus: select, write and read strobes decode the access.
// - Enable bus: with enable high, select and direction decode access.
// - Byte strobe bus: with strobe low, select and direction decode.
// - First init byte: bits 7,6,1 zero, bit 4 one, rest are fields.
// - Second init byte: bit 7 frame drive, bits 3-0 width, 6-4 zero.
// - Code 46h loads the 16-bit pointer from two bytes, low first.
// - After code 47h reads return pointer low byte then high byte.
// - Each store and each host read after code 43h advances the pointer; the 43h prime does not.
module ici_core (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        register_select_line_i,
   input  wire logic        wr_n_i,
   input  wire logic        rd_n_i,
   input  wire logic        rw_i,
   input  wire logic        enable_i,
   input  wire logic        lower_byte_strobe_n_i,
   input  wire logic [7:0]  host_data_i,
   output logic      [7:0]  host_data_o,
   output logic             host_data_oe_o,
   output logic      [15:0] mem_addr_o,
   output logic      [7:0]  mem_wdata_o,
   output logic             mem_we_o,
   output logic             mem_re_o,
   input  wire logic [7:0]  mem_rdata_i,
   output logic             standby_o,
   output logic             normal_o,
   output logic             screen_on_o,
   output logic             origin_offset_select_o,
   output logic             panel_drive_select_o,
   output logic             glyph_height_select_o,
   output logic             glyph_source_select_o,
   output logic             ac_drive_frame_select_o,
   output logic      [3:0]  glyph_width_o
);
   import ici_pkg::*;

   // ****
   // State
   // ****
   typedef struct packed {
      ici_kind_t   kind;
      logic [5:0]  base;
      logic [4:0]  left;
      logic [3:0]  ofs;
      logic        is_init;
      logic [1:0]  mode;
      logic        standby;
      logic        normal;
      logic        screen_on;
      logic [15:0] cursor;
      logic        rd_hi;
      logic [7:0]  prefetch;
      logic        pf_pend;
      logic        busy;
      logic [7:0]  hdata;
      logic        hoe;
      logic        mem_we;
      logic        mem_re;
      logic [15:0] mem_addr;
      logic [7:0]  mem_wdata;
      logic        origin;
      logic        panel;
      logic        gheight;
      logic        gsrc;
      logic        acframe;
      logic [3:0]  gwidth;
      logic        wb_stage;
      logic        wb_ack;
      logic [31:0] wb_dat;
   } ici_state_t;

   ici_state_t s_q;
   ici_state_t s_d;

   ici_acc_t    acc;
   logic        start;
   logic        rf_we;
   logic [5:0]  rf_waddr;
   logic [7:0]  rf_wdata;
   logic [7:0]  rf_rdata;
   logic [7:0]  wd;
   logic [15:0] wb_idx;
   logic        wb_is_cfg;

   ici_regfile u_regfile (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .we_i    (rf_we),
      .waddr_i (rf_waddr),
      .wdata_i (rf_wdata),
      .raddr_i (wb_idx[5:0]),
      .rdata_o (rf_rdata)
   );

   assign wb_idx    = wb_adr_i[17:2];
   assign wb_is_cfg = (wb_idx[15:6] == WB_CFG_PAGE) &&
                      (wb_idx[5:0] <= IDX_LAST);

   // ****
   // Next state
   // ****
   always_comb begin
      s_d       = s_q;
      acc       = ICI_A_NONE;
      rf_we     = 1'b0;
      rf_waddr  = IDX_INIT;
      rf_wdata  = RF_RESET;
      wd        = host_data_i;
      s_d.mem_we = 1'b0;
      s_d.mem_re = 1'b0;

      // Access decode per bus flavour
      case (s_q.mode)
         MODE_ENABLE: begin
            if (enable_i) begin
               if (register_select_line_i) begin
                  acc = rw_i ? ICI_A_PRD : ICI_A_CMD;
               end else if (!rw_i) begin
                  acc = ICI_A_PWR;
               end
            end
         end
         MODE_DSTROBE: begin
            if (!lower_byte_strobe_n_i) begin
               if (register_select_line_i) begin
                  acc = rw_i ? ICI_A_PRD : ICI_A_CMD;
               end else if (!rw_i) begin
                  acc = ICI_A_PWR;
               end
            end
         end
         default: begin
            if (register_select_line_i && !wr_n_i && rd_n_i) begin
               acc = ICI_A_CMD;
            end else if (register_select_line_i && wr_n_i && !rd_n_i) begin
               acc = ICI_A_PRD;
            end else if (!register_select_line_i && !wr_n_i && rd_n_i) begin
               acc = ICI_A_PWR;
            end
         end
      endcase

      // One action per strobe, however long the host holds it
      start    = (acc != ICI_A_NONE) && !s_q.busy;
      s_d.busy = (acc != ICI_A_NONE);
      s_d.hoe  = (acc == ICI_A_PRD);

      // Prefetched byte lands one cycle after the read pulse
      s_d.pf_pend = s_q.mem_re;
      if (s_q.pf_pend) begin
         s_d.prefetch = mem_rdata_i;
      end

      if (start && acc == ICI_A_CMD) begin
         s_d.kind    = ICI_K_PARAM;
         s_d.left    = LEN_NONE;
         s_d.ofs     = OFS_P1;
         s_d.is_init = 1'b0;
         s_d.rd_hi   = 1'b0;
         if ((host_data_i & CMD_DIR_MASK) == CMD_DIR_BASE) begin
            s_d.kind = ICI_K_IDLE;
            rf_we    = 1'b1;
            rf_waddr = IDX_DIR;
            rf_wdata = host_data_i & CMD_DIR_BITS;
         end else begin
            case (host_data_i)
               CMD_INIT: begin
                  s_d.base    = IDX_INIT;
                  s_d.left    = LEN_INIT;
                  s_d.is_init = 1'b1;
                  s_d.standby = 1'b0;
                  s_d.normal  = 1'b0;
               end
               CMD_STANDBY: begin
                  s_d.kind    = ICI_K_IDLE;
                  s_d.standby = 1'b1;
                  s_d.normal  = 1'b0;
               end
               CMD_SCREEN_ON, CMD_SCREEN_OFF: begin
                  // Both expect the attribute byte to follow
                  s_d.base      = IDX_ATTR;
                  s_d.left      = LEN_ONE;
                  s_d.screen_on = (host_data_i == CMD_SCREEN_ON);
               end
               CMD_BLOCKS: begin
                  s_d.base = IDX_BLOCKS;
                  s_d.left = LEN_BLOCKS;
               end
               CMD_POINTER_FORM: begin
                  s_d.base = IDX_FORM;
                  s_d.left = LEN_TWO;
               end
               CMD_LAYER_MIX: begin
                  s_d.base = IDX_MIX;
                  s_d.left = LEN_ONE;
               end
               CMD_GLYPH_BASE: begin
                  s_d.base = IDX_GLYPH;
                  s_d.left = LEN_TWO;
               end
               CMD_FINE_SHIFT: begin
                  s_d.base = IDX_SHIFT;
                  s_d.left = LEN_ONE;
               end
               CMD_DEPTH: begin
                  s_d.base = IDX_DEPTH;
                  s_d.left = LEN_ONE;
               end
               CMD_PTR_SET: begin
                  s_d.base = IDX_PTR;
                  s_d.left = LEN_TWO;
               end
               CMD_PTR_GET: begin
                  s_d.kind = ICI_K_PTRGET;
               end
               CMD_STORE: begin
                  s_d.kind = ICI_K_STORE;
               end
               CMD_FETCH: begin
                  // Prime the first byte so the first read has data
                  s_d.kind     = ICI_K_FETCH;
                  s_d.mem_re   = 1'b1;
                  s_d.mem_addr = s_q.cursor;
               end
               default: begin
                  s_d.kind = ICI_K_IDLE;
               end
            endcase
         end
      end

      if (start && acc == ICI_A_PWR) begin
         unique case (s_q.kind)
            ICI_K_STORE: begin
               s_d.mem_we    = 1'b1;
               s_d.mem_addr  = s_q.cursor;
               s_d.mem_wdata = host_data_i;
               s_d.cursor    = s_q.cursor + 16'h0001;
            end
            ICI_K_PARAM: begin
               if (s_q.left != LEN_NONE) begin
                  if (s_q.is_init && s_q.ofs == OFS_P1) begin
                     wd = (host_data_i & P1_KEEP) | P1_ONE;
                     s_d.origin  = host_data_i[BIT_ORIGIN];
                     s_d.panel   = host_data_i[BIT_PANEL];
                     s_d.gheight = host_data_i[BIT_GHEIGHT];
                     s_d.gsrc    = host_data_i[BIT_GSRC];
                  end
                  if (s_q.is_init && s_q.ofs == OFS_P2) begin
                     wd = host_data_i & P2_KEEP;
                     s_d.acframe = host_data_i[BIT_ACFRAME];
                     s_d.gwidth  = host_data_i[3:0];
                  end
                  if (s_q.is_init && s_q.left == LEN_ONE) begin
                     s_d.normal = 1'b1;
                  end
                  if (s_q.base == IDX_PTR) begin
                     if (s_q.ofs == OFS_P1) begin
                        s_d.cursor[7:0] = host_data_i;
                     end else begin
                        s_d.cursor[15:8] = host_data_i;
                     end
                  end
                  rf_we    = 1'b1;
                  rf_waddr = s_q.base + {2'b00, s_q.ofs};
                  rf_wdata = wd;
                  s_d.ofs  = s_q.ofs + 4'h1;
                  s_d.left = s_q.left - LEN_ONE;
               end
            end
            ICI_K_IDLE, ICI_K_FETCH, ICI_K_PTRGET: begin
            end
            default: begin
               s_d.kind = ICI_K_IDLE;
            end
         endcase
      end

      if (start && acc == ICI_A_PRD) begin
         s_d.hdata = RF_RESET;
         if (s_q.kind == ICI_K_PTRGET) begin
            s_d.hdata = s_q.rd_hi ? s_q.cursor[15:8] : s_q.cursor[7:0];
            s_d.rd_hi = !s_q.rd_hi;
         end else if (s_q.kind == ICI_K_FETCH) begin
            // Hand out the prefetched byte, then fetch the next one
            s_d.hdata    = s_q.prefetch;
            s_d.cursor   = s_q.cursor + 16'h0001;
            s_d.mem_re   = 1'b1;
            s_d.mem_addr = s_q.cursor + 16'h0001;
         end
      end

      // ****
      // Wishbone slave, answer two cycles after the request
      // ****
      s_d.wb_ack = s_q.wb_stage;
      // Write lands only at the edge the master sees ack
      if (s_q.wb_ack && wb_we_i && wb_sel_i[0] && wb_idx == WB_CTRL_IDX) begin
         s_d.mode = wb_dat_i[1:0];
      end
      if (s_q.wb_stage) begin
         s_d.wb_stage = 1'b0;
         s_d.wb_dat   = 32'h0000_0000;
         if (wb_is_cfg) begin
            s_d.wb_dat = {24'h00_0000, rf_rdata};
         end else if (wb_idx == WB_CTRL_IDX) begin
            s_d.wb_dat = {30'h0000_0000, s_q.mode};
         end else if (wb_idx == WB_STAT_IDX) begin
            s_d.wb_dat = {s_q.cursor, 10'h000, s_q.kind,
                          s_q.screen_on, s_q.normal, s_q.standby};
         end
      end else if (wb_cyc_i && wb_stb_i && !s_q.wb_ack) begin
         s_d.wb_stage = 1'b1;
      end
   end

   // ****
   // Registers
   // ****
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q         <= '0;
         s_q.kind    <= ICI_K_IDLE;
         s_q.mode    <= MODE_GENERIC;
         s_q.standby <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o                = s_q.wb_dat;
   assign wb_ack_o                = s_q.wb_ack;
   assign host_data_o             = s_q.hdata;
   assign host_data_oe_o          = s_q.hoe;
   assign mem_addr_o              = s_q.mem_addr;
   assign mem_wdata_o             = s_q.mem_wdata;
   assign mem_we_o                = s_q.mem_we;
   assign mem_re_o                = s_q.mem_re;
   assign standby_o               = s_q.standby;
   assign normal_o                = s_q.normal;
   assign screen_on_o             = s_q.screen_on;
   assign origin_offset_select_o  = s_q.origin;
   assign panel_drive_select_o    = s_q.panel;
   assign glyph_height_select_o   = s_q.gheight;
   assign glyph_source_select_o   = s_q.gsrc;
   assign ac_drive_frame_select_o = s_q.acframe;
   assign glyph_width_o           = s_q.gwidth;

endmodule
`default_nettype wire

// ==== verification/ici_core_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module ici_core_sva (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       wb_cyc_i,
   input  wire logic       wb_stb_i,
   input  wire logic       wb_ack_o,
   input  wire logic       register_select_line_i,
   input  wire logic       wr_n_i,
   input  wire logic       rd_n_i,
   input  wire logic [7:0] host_data_i,
   input  wire logic       host_data_oe_o,
   input  wire logic       mem_we_o,
   input  wire logic       mem_re_o,
   input  wire logic       standby_o,
   input  wire logic       normal_o,
   input  wire logic       screen_on_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic       cmd, pw, rd, cmd_q, pw_q;
   logic [3:0] cnt_q;
   // Generic decode only; other modes hold both strobes high
   assign cmd = register_select_line_i & !wr_n_i & rd_n_i;
   assign pw  = !register_select_line_i & !wr_n_i & rd_n_i;
   assign rd  = register_select_line_i & wr_n_i & !rd_n_i;
   always_ff @(posedge clk_i) begin
      cmd_q <= rst_i ? 1'b0 : cmd;
      pw_q  <= rst_i ? 1'b0 : pw;
      if (rst_i || (cmd && !cmd_q)) cnt_q <= 4'h0;
      else if (pw && !pw_q && cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
   end
   // ****
   // Assertions
   // ****
   property p_ack_lat;
      $rose(wb_cyc_i && wb_stb_i) |-> !wb_ack_o [*2] ##1 wb_ack_o;
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack latency");
   property p_ack_one;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   property p_sby;
      $rose(cmd) && host_data_i == 8'h53 |=> standby_o && !normal_o;
   endproperty
   a_sby: assert property (p_sby) else $error("standby entry");
   property p_init;
      $rose(cmd) && host_data_i == 8'h40 |=> !standby_o && !normal_o;
   endproperty
   a_init: assert property (p_init) else $error("init exit");
   property p_norm;
      $rose(normal_o) |-> cnt_q == 4'h8;
   endproperty
   a_norm: assert property (p_norm) else $error("normal early");
   property p_scr;
      $rose(cmd) && host_data_i[7:1] == 7'h2c
         |=> screen_on_o == $past(host_data_i[0]);
   endproperty
   a_scr: assert property (p_scr) else $error("screen flag");
   property p_oe_on;
      $rose(rd) |=> host_data_oe_o;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("oe late");
   property p_oe_off;
      $fell(rd) |=> !host_data_oe_o;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("oe stuck");
   property p_we_one;
      mem_we_o |=> !mem_we_o;
   endproperty
   a_we_one: assert property (p_we_one) else $error("we pulse");
   c_norm: cover property ($rose(normal_o));
   c_oe: cover property ($rose(host_data_oe_o));
   c_we: cover property (mem_we_o);
endmodule
`default_nettype wire

// ==== verification/ici_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ici_host_model (
   input  wire logic        clk_i,
   output logic             a0_o,
   output logic             wr_n_o,
   output logic             rd_n_o,
   output logic             rw_o,
   output logic             en_o,
   output logic             lds_n_o,
   output logic [7:0]       data_o,
   input  wire logic [7:0]  data_i,
   input  wire logic [15:0] maddr_i,
   input  wire logic [7:0]  mwdata_i,
   input  wire logic        mwe_i,
   input  wire logic        mre_i,
   output logic [7:0]       mrdata_o
);
   logic [7:0] ram [0:255];
   initial begin
      {a0_o, rw_o, en_o} = 3'h0;
      {wr_n_o, rd_n_o, lds_n_o} = 3'h7;
      data_o = 8'h00;
      mrdata_o = 8'h00;
   end
   // Stale read data flips so it never passes for fresh
   always @(posedge clk_i) begin
      if (mwe_i) ram[maddr_i[7:0]] <= mwdata_i;
      mrdata_o <= mre_i ? ram[maddr_i[7:0]] : ~mrdata_o;
   end
   // ****
   // Host side: kind 0 command, 1 write, 2 read
   // ****
   task automatic acc(input logic [1:0] m, input int k,
                      input logic [7:0] d, output logic [7:0] q);
      q = 8'h00;
      @(posedge clk_i);
      a0_o    <= (k != 1);
      wr_n_o  <= !(m == 2'h0 && k != 2);
      rd_n_o  <= !(m == 2'h0 && k == 2);
      rw_o    <= (m != 2'h0 && k == 2);
      en_o    <= (m == 2'h1);
      lds_n_o <= (m != 2'h2);
      data_o  <= d;
      @(posedge clk_i);
      if (k == 2) begin
         @(posedge clk_i);
         q = data_i;
      end
      {wr_n_o, rd_n_o, lds_n_o} <= 3'h7;
      {rw_o, en_o} <= 2'h0;
      data_o <= ~d;
      @(posedge clk_i);
      @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

// ==== verification/ici_core_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module ici_core_test;
   import ici_pkg::*;
   logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
   logic [3:0]  wb_sel_i, glyph_width_o;
   logic        register_select_line_i, wr_n_i, rd_n_i, rw_i, enable_i;
   logic        lower_byte_strobe_n_i, host_data_oe_o, mem_we_o, mem_re_o;
   logic [7:0]  host_data_i, host_data_o, mem_wdata_o, mem_rdata_i;
   logic [15:0] mem_addr_o;
   logic        standby_o, normal_o, screen_on_o, origin_offset_select_o;
   logic        panel_drive_select_o, glyph_height_select_o;
   logic        glyph_source_select_o, ac_drive_frame_select_o;
   logic [1:0]  mode;
   logic [7:0]  hx;
   logic [7:0]  exp_q [0:63] = '{default: 8'h00};
   int          err_count, n_checks, tick;
   ici_core i_ici_core (
      .clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
      .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .register_select_line_i,
      .wr_n_i, .rd_n_i, .rw_i, .enable_i, .lower_byte_strobe_n_i,
      .host_data_i, .host_data_o, .host_data_oe_o, .mem_addr_o,
      .mem_wdata_o, .mem_we_o, .mem_re_o, .mem_rdata_i, .standby_o,
      .normal_o, .screen_on_o, .origin_offset_select_o,
      .panel_drive_select_o, .glyph_height_select_o,
      .glyph_source_select_o, .ac_drive_frame_select_o, .glyph_width_o);
   ici_host_model i_ici_host_model (
      .clk_i, .a0_o(register_select_line_i), .wr_n_o(wr_n_i),
      .rd_n_o(rd_n_i), .rw_o(rw_i), .en_o(enable_i),
      .lds_n_o(lower_byte_strobe_n_i), .data_o(host_data_i),
      .data_i(host_data_o), .maddr_i(mem_addr_o), .mwdata_i(mem_wdata_o),
      .mwe_i(mem_we_o), .mre_i(mem_re_o), .mrdata_o(mem_rdata_i));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk_i) begin
      tick++;
      if (tick == 20000) begin
         err_count++;
         give_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [15:0] idx,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_adr_i <= {14'h0, idx, 2'b00};
      wb_we_i  <= w;
      wb_dat_i <= d;
      {wb_cyc_i, wb_stb_i} <= 2'h3;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
   endtask
   task automatic rs(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] q;
      wb(1'b0, 16'h8000 + 16'(idx), 32'h0, q);
      chk("slot", {24'h0, e}, q);
   endtask
   task automatic hc(input logic [7:0] d);
      i_ici_host_model.acc(mode, 0, d, hx);
   endtask
   task automatic hw(input logic [7:0] d);
      i_ici_host_model.acc(mode, 1, d, hx);
   endtask
   task automatic hr(input logic [7:0] e, input string nm);
      i_ici_host_model.acc(mode, 2, 8'h00, hx);
      chk(nm, {24'h0, e}, {24'h0, hx});
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_init(input logic [7:0] p1, input logic [7:0] p2);
      hc(8'h40);
      chk("standby", 32'h0, {31'h0, standby_o});
      for (int i = 0; i < 8; i++) begin
         chk("normal", 32'h0, {31'h0, normal_o});
         hw(i == 0 ? p1 : i == 1 ? p2 : 8'(i));
         exp_q[i] = i == 0 ? (p1 & 8'h2d) | 8'h10
                  : i == 1 ? p2 & 8'h8f : 8'(i);
      end
      chk("normal", 32'h1, {31'h0, normal_o});
      chk("fields", {23'h0, p1[5], p1[3], p1[2], p1[0], p2[7], p2[3:0]},
          {23'h0, origin_offset_select_o, panel_drive_select_o,
           glyph_height_select_o, glyph_source_select_o,
           ac_drive_frame_select_o, glyph_width_o});
      rs(8'h00, exp_q[0]);
      rs(8'h01, exp_q[1]);
   endtask
   task automatic t_params();
      logic [7:0] cd [7] = '{8'h59, 8'h58, 8'h44, 8'h5b, 8'h5c, 8'h5a, 8'h60};
      int ln [7] = '{1, 1, 10, 1, 2, 1, 1};
      int bs [7] = '{10, 10, 11, 24, 25, 27, 32};
      for (int i = 0; i < 7; i++) begin
         hc(cd[i]);
         for (int j = 0; j <= ln[i]; j++) begin
            hw(8'(16 * i + j + 1));
            if (j < ln[i]) exp_q[bs[i] + j] = 8'(16 * i + j + 1);
         end
         if (i < 2) chk("screen_on", {31'h0, cd[i][0]},
                        {31'h0, screen_on_o});
      end
      for (int c = 'h4c; c <= 'h4f; c++) begin
         hc(8'(c));
         rs(8'h17, 8'(c & 3));
         exp_q[8'h17] = 8'(c & 3);
      end
   endtask
   task automatic t_ptr();
      logic [31:0] q;
      hc(8'h46);
      hw(8'h34);
      hw(8'h12);
      hc(8'h47);
      hr(8'h34, "ptr_lo");
      hr(8'h12, "ptr_hi");
      hc(8'h42);
      for (int i = 0; i < 3; i++) hw(8'ha0 + 8'(i));
      hc(8'h46);
      hw(8'h34);
      hw(8'h12);
      hc(8'h43);
      for (int i = 0; i < 3; i++) hr(8'ha0 + 8'(i), "fetch");
      wb(1'b0, WB_STAT_IDX, 32'h0, q);
      chk("pointer", 32'h1237, {16'h0, q[31:16]});
   endtask
   task automatic t_modes();
      logic [31:0] q;
      wb(1'b1, WB_CTRL_IDX, 32'h1, q);
      mode = 2'h1;
      hc(8'h59);
      hw(8'h77);
      exp_q[8'h0a] = 8'h77;
      chk("screen_on", 32'h1, {31'h0, screen_on_o});
      hc(8'h47);
      hr(8'h37, "ptr_lo");
      wb(1'b1, WB_CTRL_IDX, 32'h2, q);
      mode = 2'h2;
      hc(8'h58);
      hw(8'h66);
      exp_q[8'h0a] = 8'h66;
      chk("screen_on", 32'h0, {31'h0, screen_on_o});
      wb(1'b0, WB_CTRL_IDX, 32'h0, q);
      chk("ctrl", 32'h2, {30'h0, q[1:0]});
      wb(1'b1, WB_CTRL_IDX, 32'h0, q);
      mode = 2'h0;
   endtask
   initial begin
      logic [31:0] q;
      rst_i = 1'b1;
      {wb_adr_i, wb_dat_i} = 64'h0;
      {wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
      wb_sel_i = 4'hf;
      mode = 2'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 16'h9000, 32'h0, q);
      chk("unmapped", 32'h0, q);
      chk("standby", 32'h1, {31'h0, standby_o});
      t_init(8'hff, 8'hff);
      hc(8'h53);
      chk("standby", 32'h1, {31'h0, standby_o});
      chk("normal", 32'h0, {31'h0, normal_o});
      t_init(8'h00, 8'h70);
      t_params();
      t_ptr();
      t_modes();
      for (int i = 0; i <= 'h20; i++)
         if (i < 'h1c || i > 'h1f) rs(8'(i), exp_q[i]);
      give_verdict();
   end
endmodule
bind ici_core ici_core_sva i_ici_core_sva (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .register_select_line_i, .wr_n_i, .rd_n_i, .host_data_i,
   .host_data_oe_o, .mem_we_o, .mem_re_o, .standby_o, .normal_o,
   .screen_on_o);
`default_nettype wire
